// [bench/tb_timer8_compare.sv]
// Self-checking bench for the compare timer slice
`timescale 1ns/1ns
module tb_timer8_compare;
  import timer8_pkg::*;
  logic               sys_clk_i, rst_i;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic               s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               overflow_serviced_i, compare_a_serviced_i, compare_b_serviced_i;
  logic               overflow_flag_o, compare_flag_a_o, compare_flag_b_o;
  logic               compare_pin_a_o, compare_pin_a_oe_o, compare_pin_b_o, compare_pin_b_oe_o;
  int                 n_fail, n_compared, n;
  logic [31:0]        rd;
  logic [1:0]         rs;

  timer8_compare u_dut (.*);

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Valid raised at once; each channel released on its own handshake
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge sys_clk_i);
      if (s_axi_bvalid && s_axi_bready) begin
        b = 1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // One idle edge, so a next call never re-drives bready in this step
    @(posedge sys_clk_i);
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    bit ar, r;
    ar = 0;
    r = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge sys_clk_i);
      if (s_axi_rvalid && s_axi_rready) begin
        r = 1;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
      if (!ar && s_axi_arready) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    @(posedge sys_clk_i);
  endtask

  task automatic ctrl(input logic [1:0] act, input logic [2:0] mode, input logic [2:0] cs);
    wr(OFS_CTRL, {22'h0, cs, mode, 2'h0, act});
  endtask

  // Cycles until pin A next changes, bounded
  task automatic pin_gap(output int k);
    logic p;
    p = compare_pin_a_o;
    k = 0;
    while (compare_pin_a_o === p && k < 3000) begin
      @(posedge sys_clk_i);
      k++;
    end
  endtask

  task automatic t_reset();
    logic [ADDR_W-1:0] ofs [5] = '{OFS_CTRL, OFS_COUNT, OFS_CMPA, OFS_FLAGS, OFS_PORT};
    foreach (ofs[i]) begin
      rdr(ofs[i]);
      check(rd, 32'h0);
    end
    rdr(5'h1C);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(5'h1C, 32'h0000_00FF);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask

  // Latch set up while the pin is still an input
  task automatic t_force();
    logic [1:0] acts [5] = '{ACT_CLEAR, ACT_SET, ACT_NONE, ACT_TOGGLE, ACT_TOGGLE};
    logic       exps [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    wr(OFS_PORT, 32'h0);
    foreach (acts[i]) begin
      ctrl(acts[i], MODE_NORMAL, CSEL_STOP);
      wr(OFS_FORCE, 32'h1);
      rdr(OFS_PORT);
      check({31'h0, rd[PRT_LAT_A]}, {31'h0, exps[i]});
      check({31'h0, compare_pin_a_oe_o}, 32'h0);
    end
    rdr(OFS_FLAGS);
    check(rd, 32'h0);
    rdr(OFS_COUNT);
    check(rd, 32'h0);
    wr(OFS_PORT, 32'h2);
    ctrl(ACT_TOGGLE, MODE_NORMAL, CSEL_STOP);
    repeat (2) @(posedge sys_clk_i);
    check({30'h0, compare_pin_a_oe_o, compare_pin_a_o}, 32'h3);
    ctrl(ACT_NONE, MODE_CTC, CSEL_STOP);
    repeat (2) @(posedge sys_clk_i);
    check({30'h0, compare_pin_a_oe_o, compare_pin_a_o}, 32'h2);
    wr(OFS_PORT, 32'hA);
    wr(OFS_CTRL, {28'h0, ACT_SET, ACT_NONE});
    check({30'h0, compare_pin_b_oe_o, compare_pin_b_o}, 32'h2);
    wr(OFS_FORCE, 32'h2);
    check({30'h0, compare_pin_b_oe_o, compare_pin_b_o}, 32'h3);
  endtask

  task automatic t_overflow();
    ctrl(ACT_NONE, MODE_NORMAL, CSEL_STOP);
    wr(OFS_COUNT, 32'hFC);
    rdr(OFS_COUNT);
    check(rd, 32'hFC);
    rdr(OFS_COUNT);
    check(rd, 32'hFC);
    ctrl(ACT_NONE, MODE_NORMAL, 3'h1);
    n = 0;
    while (overflow_flag_o !== 1'b1 && n < 50) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({31'h0, overflow_flag_o}, 32'h1);
    rdr(OFS_COUNT);
    check({31'h0, rd < 32'h10}, 32'h1);
    check({30'h0, compare_flag_b_o, compare_flag_a_o}, 32'h3);
    {overflow_serviced_i, compare_a_serviced_i, compare_b_serviced_i} <= 3'h7;
    @(posedge sys_clk_i);
    {overflow_serviced_i, compare_a_serviced_i, compare_b_serviced_i} <= 3'h0;
    repeat (2) @(posedge sys_clk_i);
    check({29'h0, overflow_flag_o, compare_flag_a_o, compare_flag_b_o}, 32'h0);
  endtask

  // Equal count and compare must not match right after the count write
  task automatic t_block();
    ctrl(ACT_NONE, MODE_NORMAL, CSEL_STOP);
    wr(OFS_CMPA, 32'h5);
    wr(OFS_COUNT, 32'h5);
    wr(OFS_FLAGS, 32'h7);
    ctrl(ACT_NONE, MODE_NORMAL, 3'h1);
    repeat (3) @(posedge sys_clk_i);
    check({31'h0, compare_flag_a_o}, 32'h0);
    n = 0;
    while (compare_flag_a_o !== 1'b1 && n < 300) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({31'h0, compare_flag_a_o}, 32'h1);
  endtask

  // Half period is prescale times one plus compare A
  task automatic t_ctc();
    logic [2:0] cs [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0] cm [7] = '{8'h03, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    int         gap [7] = '{4, 8, 64, 128, 256, 512, 2048};
    ctrl(ACT_NONE, MODE_NORMAL, CSEL_STOP);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_FLAGS, 32'h7);
    foreach (cs[i]) begin
      wr(OFS_CMPA, {24'h0, cm[i]});
      ctrl(ACT_TOGGLE, MODE_CTC, cs[i]);
      // First change may still come from the old select's last tick
      repeat (3) pin_gap(n);
      check(n, gap[i]);
    end
    check({31'h0, compare_flag_a_o}, 32'h1);
    rdr(OFS_COUNT);
    check({31'h0, rd <= 32'h1}, 32'h1);
    ctrl(ACT_NONE, MODE_NORMAL, CSEL_STOP);
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {overflow_serviced_i, compare_a_serviced_i, compare_b_serviced_i} = '0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_force();
    t_overflow();
    t_block();
    t_ctc();
    conclude();
  end
endmodule

// [bench/timer8_compare_asserts.sv]
// Bus handshake and flag checks for the compare timer
`timescale 1ns/1ns
module timer8_compare_asserts
  import timer8_pkg::*;
(
  // Clock and reset
  input wire logic                          sys_clk_i,
  input wire logic                          rst_i,
  // Bus
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [timer8_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [timer8_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  // Flags and pin
  input wire logic                          overflow_serviced_i,
  input wire logic                          compare_a_serviced_i,
  input wire logic                          overflow_flag_o,
  input wire logic                          compare_flag_a_o,
  input wire logic                          compare_pin_a_o,
  input wire logic                          compare_pin_a_oe_o
);
  import timer8_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken early");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h1C
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  // Counting only sets flags; a fall needs a service pulse or a clearing write
  chk_ovf_only_set: assert property ($fell(overflow_flag_o) |-> $past(overflow_serviced_i)
    || $past(overflow_serviced_i, 2) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("overflow flag fell unasked");
  chk_cmpa_only_set: assert property ($fell(compare_flag_a_o) |->
    $past(compare_a_serviced_i) || $past(compare_a_serviced_i, 2) || s_axi_bvalid
    || $past(s_axi_bvalid)) else $error("compare flag fell unasked");
  chk_dir_by_write: assert property ($changed(compare_pin_a_oe_o)
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin direction moved alone");
  cov_overflow: cover property ($rose(overflow_flag_o));
  cov_toggle: cover property (compare_pin_a_oe_o && $changed(compare_pin_a_o));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind timer8_compare timer8_compare_asserts u_chk (.*);

// [logic/timer8_compare.sv]
// Eight-bit timer with compare outputs, normal and clear-on-match modes
//
// How it works
// R1: Action field decides latch change at match
// R2: Nonzero action field gives latch to pin
// R3: Pin drives only when direction bit outputs
// R4: Override ignores waveform mode entirely
// R5: Latch can be set while pin input
// R6: Action zero leaves latch unchanged
// R7: New action field acts at next match
// R8: Force strobe applies action now, non-PWM
// R9: Only mode field shapes the count sequence
// R10: Action field selects set, clear or toggle
// R11: Mode zero counts up, wraps FF to 00
// R12: Normal mode sets overflow on reaching zero
// R13: Servicing overflow interrupt clears its flag
// R14: Counter writable at any time
// R15: Mode two clears counter at compare A
// R16: Compare A unbuffered; low value wraps first
// R17: Compare A flag raised at each top
// R18: Action one toggles latch every match
// R19: Toggle rate clk over 2N(1+A)
// R20: Prescale choices 1,8,32,64,128,256,1024
// R21: Clear mode sets overflow passing max
// R22: Force never sets flags or touches counter
// R23: Counter write blocks next-tick matches
// R24: Compare flag set at next timer tick
// R25: Select zero stops; writes beat counting
// R26: Action two clears, three sets latch
// R27: Counter and flags move only on tick; counter writes, flag writes and service pulses act off-tick too
`timescale 1ns/1ns
module timer8_compare
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [timer8_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [timer8_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [timer8_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [timer8_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // Interrupt service acknowledges
  input  wire logic                          overflow_serviced_i,
  input  wire logic                          compare_a_serviced_i,
  input  wire logic                          compare_b_serviced_i,
  // Flags toward the interrupt controller
  output logic                               overflow_flag_o,
  output logic                               compare_flag_a_o,
  output logic                               compare_flag_b_o,
  // Compare pins
  output logic                               compare_pin_a_o,
  output logic                               compare_pin_a_oe_o,
  output logic                               compare_pin_b_o,
  output logic                               compare_pin_b_oe_o
);
  typedef struct packed {
    logic [7:0]        counter_value;
    logic [7:0]        compare_register_a;
    logic [7:0]        compare_register_b;
    logic [1:0]        compare_action_field_a;
    logic [1:0]        compare_action_field_b;
    logic [2:0]        waveform_mode_field;
    logic [2:0]        clock_select_field;
    logic              overflow_flag;
    logic              compare_flag_a;
    logic              compare_flag_b;
    logic              match_block;
    logic              compare_output_latch_a;
    logic              compare_output_latch_b;
    logic              port_out_a;
    logic              port_out_b;
    logic              dir_a;
    logic              dir_b;
    logic              pin_a;
    logic              pin_b;
    logic              aw_have;
    logic [ADDR_W-1:0] waddr;
    logic              w_have;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   timer_clock_enable;

  timer8_prescaler #(
    .W (PRESC_W)
  ) u_presc (
    .sys_clk_i            (sys_clk_i),
    .rst_i                (rst_i),
    .clock_select_field_i (s_q.clock_select_field),
    .timer_clock_enable_o (timer_clock_enable)
  );

  // Latch update for one compare event
  function automatic logic apply_action(input logic lat, input logic [1:0] act);
    case (act)
      ACT_TOGGLE: apply_action = ~lat;  // R18 R19
      ACT_CLEAR:  apply_action = 1'b0;  // R26
      ACT_SET:    apply_action = 1'b1;  // R26
      default:    apply_action = lat;   // R6
    endcase
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [3:0]        be);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_COUNT) || (a == OFS_CMPA) ||
                (a == OFS_CMPB) || (a == OFS_FLAGS) || (a == OFS_FORCE) ||
                (a == OFS_PORT);
  endfunction

  function automatic logic non_pwm(input logic [2:0] m);
    non_pwm = (m == MODE_NORMAL) || (m == MODE_CTC);
  endfunction

  always_comb begin
    logic              match_a;
    logic              match_b;
    logic              ctc_clear;
    logic              set_ovf;
    logic              set_a;
    logic              set_b;
    logic              do_wr;
    logic [DATA_W-1:0] ctrl_w;
    logic [DATA_W-1:0] wv;
    match_a   = 1'b0;
    match_b   = 1'b0;
    ctc_clear = 1'b0;
    set_ovf   = 1'b0;
    set_a     = 1'b0;
    set_b     = 1'b0;
    do_wr     = 1'b0;
    ctrl_w    = '0;
    wv        = '0;
    s_d       = s_q;

    // Matches are blocked for one tick after a counter write
    match_a = !s_q.match_block &&
              (s_q.counter_value == s_q.compare_register_a); // R23
    match_b = !s_q.match_block &&
              (s_q.counter_value == s_q.compare_register_b); // R23

    // Counting, only on the prescaled enable
    if (timer_clock_enable) begin // R27 R25
      s_d.match_block = 1'b0;
      ctc_clear = (s_q.waveform_mode_field == MODE_CTC) && match_a; // R9 R15
      if (ctc_clear) begin
        s_d.counter_value = CNT_BOTTOM; // R15 R17
      end else begin
        s_d.counter_value = s_q.counter_value + 8'h01; // R11 R16
      end
      set_ovf = (s_q.counter_value == CNT_MAX) && !ctc_clear; // R12 R21
      set_a   = match_a; // R24 R17
      set_b   = match_b; // R24
      if (match_a) begin
        s_d.compare_output_latch_a =
          apply_action(s_q.compare_output_latch_a,
                       s_q.compare_action_field_a); // R1 R7 R10
      end
      if (match_b) begin
        s_d.compare_output_latch_b =
          apply_action(s_q.compare_output_latch_b,
                       s_q.compare_action_field_b); // R1 R7 R10
      end
    end

    // Flags cleared by interrupt service
    if (overflow_serviced_i) begin
      s_d.overflow_flag = 1'b0; // R13
    end
    if (compare_a_serviced_i) begin
      s_d.compare_flag_a = 1'b0;
    end
    if (compare_b_serviced_i) begin
      s_d.compare_flag_b = 1'b0;
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    do_wr = s_d.aw_have && s_d.w_have && !s_q.bvalid;
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = is_mapped(s_d.waddr) ? RESP_OKAY : RESP_SLVERR;
      wv          = merge('0, s_d.wdata, s_d.wstrb);
      case (s_d.waddr)
        OFS_CTRL: begin
          ctrl_w = {22'h0, s_q.clock_select_field, s_q.waveform_mode_field,
                    s_q.compare_action_field_b, s_q.compare_action_field_a};
          ctrl_w = merge(ctrl_w, s_d.wdata, s_d.wstrb);
          s_d.compare_action_field_a = ctrl_w[CTRL_ACT_A +: 2]; // R7
          s_d.compare_action_field_b = ctrl_w[CTRL_ACT_B +: 2];
          s_d.waveform_mode_field    = ctrl_w[CTRL_MODE +: 3];
          s_d.clock_select_field     = ctrl_w[CTRL_CSEL +: 3];
        end
        OFS_COUNT: begin
          if (s_d.wstrb[0]) begin
            s_d.counter_value = s_d.wdata[7:0]; // R14 R25
            s_d.match_block   = 1'b1;           // R23
          end
        end
        OFS_CMPA: begin
          if (s_d.wstrb[0]) begin
            s_d.compare_register_a = s_d.wdata[7:0]; // R16
          end
        end
        OFS_CMPB: begin
          if (s_d.wstrb[0]) begin
            s_d.compare_register_b = s_d.wdata[7:0];
          end
        end
        OFS_FLAGS: begin
          // Write one to clear
          if (wv[FLG_OVF]) begin
            s_d.overflow_flag = 1'b0;
          end
          if (wv[FLG_CMPA]) begin
            s_d.compare_flag_a = 1'b0;
          end
          if (wv[FLG_CMPB]) begin
            s_d.compare_flag_b = 1'b0;
          end
        end
        OFS_FORCE: begin
          // Forcing leaves flags and counter alone
          if (wv[FRC_A] && non_pwm(s_q.waveform_mode_field)) begin
            s_d.compare_output_latch_a =
              apply_action(s_d.compare_output_latch_a,
                           s_q.compare_action_field_a); // R8 R22 R5
          end
          if (wv[FRC_B] && non_pwm(s_q.waveform_mode_field)) begin
            s_d.compare_output_latch_b =
              apply_action(s_d.compare_output_latch_b,
                           s_q.compare_action_field_b); // R8 R22
          end
        end
        OFS_PORT: begin
          if (s_d.wstrb[0]) begin
            s_d.port_out_a = s_d.wdata[PRT_OUT_A];
            s_d.dir_a      = s_d.wdata[PRT_DIR_A];
            s_d.port_out_b = s_d.wdata[PRT_OUT_B];
            s_d.dir_b      = s_d.wdata[PRT_DIR_B];
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    if (set_ovf) begin
      s_d.overflow_flag = 1'b1; // R12 R21
    end
    if (set_a) begin
      s_d.compare_flag_a = 1'b1; // R17 R24
    end
    if (set_b) begin
      s_d.compare_flag_b = 1'b1; // R24
    end

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL:  s_d.rdata = {22'h0, s_q.clock_select_field,
                                s_q.waveform_mode_field,
                                s_q.compare_action_field_b,
                                s_q.compare_action_field_a};
        OFS_COUNT: s_d.rdata = {24'h0, s_q.counter_value};
        OFS_CMPA:  s_d.rdata = {24'h0, s_q.compare_register_a};
        OFS_CMPB:  s_d.rdata = {24'h0, s_q.compare_register_b};
        OFS_FLAGS: s_d.rdata = {29'h0, s_q.compare_flag_b, s_q.compare_flag_a,
                                s_q.overflow_flag};
        OFS_PORT:  s_d.rdata = {26'h0, s_q.compare_output_latch_b,
                                s_q.compare_output_latch_a, s_q.dir_b,
                                s_q.port_out_b, s_q.dir_a, s_q.port_out_a};
        default:   s_d.rdata = '0;
      endcase
    end

    // One write and one read in flight at most
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;

    // Pin mux; override ignores mode, drive follows direction bit
    s_d.pin_a = (s_d.compare_action_field_a != ACT_NONE) ?
                s_d.compare_output_latch_a : s_d.port_out_a; // R2 R4
    s_d.pin_b = (s_d.compare_action_field_b != ACT_NONE) ?
                s_d.compare_output_latch_b : s_d.port_out_b; // R2 R4
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready      = s_q.awready;
  assign s_axi_wready       = s_q.wready;
  assign s_axi_bvalid       = s_q.bvalid;
  assign s_axi_bresp        = s_q.bresp;
  assign s_axi_arready      = s_q.arready;
  assign s_axi_rvalid       = s_q.rvalid;
  assign s_axi_rdata        = s_q.rdata;
  assign s_axi_rresp        = s_q.rresp;
  assign overflow_flag_o    = s_q.overflow_flag;
  assign compare_flag_a_o   = s_q.compare_flag_a;
  assign compare_flag_b_o   = s_q.compare_flag_b;
  assign compare_pin_a_o    = s_q.pin_a;
  assign compare_pin_a_oe_o = s_q.dir_a; // R3
  assign compare_pin_b_o    = s_q.pin_b;
  assign compare_pin_b_oe_o = s_q.dir_b; // R3
endmodule

// [logic/timer8_prescaler.sv]
// Prescaler producing the one-cycle timer clock enable
`timescale 1ns/1ns
module timer8_prescaler
  import timer8_pkg::*;
#(
  parameter int W = timer8_pkg::PRESC_W
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Selection and enable
  input  wire logic [2:0] clock_select_field_i,
  output logic            timer_clock_enable_o
);
  typedef struct packed {
    logic [W-1:0] div;
    logic         tick;
  } presc_t;

  presc_t s_q;
  presc_t s_d;

  // Low bits all ones marks the end of one prescale period
  function automatic logic [W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    div_mask = W'(0);
      3'h2:    div_mask = W'(7);
      3'h3:    div_mask = W'(31);
      3'h4:    div_mask = W'(63);
      3'h5:    div_mask = W'(127);
      3'h6:    div_mask = W'(255);
      3'h7:    div_mask = W'(1023);
      default: div_mask = W'(0);
    endcase
  endfunction

  always_comb begin
    s_d      = s_q;
    s_d.div  = s_q.div + W'(1);
    s_d.tick = (clock_select_field_i != CSEL_STOP) &&
               ((s_q.div & div_mask(clock_select_field_i)) ==
                div_mask(clock_select_field_i)); // R20
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_clock_enable_o = s_q.tick;
endmodule

// [shared/timer8_pkg.sv]
// Shared constants for the eight-bit compare timer slice
package timer8_pkg;
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CMPA  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CMPB  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FORCE = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_PORT  = 5'h18;
  // Control register fields
  localparam int CTRL_ACT_A  = 0;
  localparam int CTRL_ACT_B  = 2;
  localparam int CTRL_MODE   = 4;
  localparam int CTRL_CSEL   = 7;
  // Flag register fields
  localparam int FLG_OVF     = 0;
  localparam int FLG_CMPA    = 1;
  localparam int FLG_CMPB    = 2;
  // Force register fields
  localparam int FRC_A       = 0;
  localparam int FRC_B       = 1;
  // Port register fields
  localparam int PRT_OUT_A   = 0;
  localparam int PRT_DIR_A   = 1;
  localparam int PRT_OUT_B   = 2;
  localparam int PRT_DIR_B   = 3;
  localparam int PRT_LAT_A   = 4;
  localparam int PRT_LAT_B   = 5;
  // Waveform modes handled here
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CTC    = 3'h2;
  // Compare actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  // Counter extremes and reset values
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CMP_RESET  = 8'h00;
  // Prescaler
  localparam int PRESC_W = 10;
  localparam logic [2:0] CSEL_STOP = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
